// file: core/dbg_pkg.sv
// ----------------------------------------------------------------
// debug command unit constants
// ----------------------------------------------------------------
package dbg_pkg;

  // hardware command opcodes
  localparam logic [7:0] OP_ENTER_DEBUG = 8'h90;
  localparam logic [7:0] OP_ACK_ON = 8'hd5;
  localparam logic [7:0] OP_ACK_OFF = 8'hd6;
  localparam logic [7:0] OP_RD_DBG_BYTE = 8'he4;
  localparam logic [7:0] OP_RD_DBG_WORD = 8'hec;
  localparam logic [7:0] OP_RD_BYTE = 8'he0;
  localparam logic [7:0] OP_RD_WORD = 8'he8;
  localparam logic [7:0] OP_WR_DBG_BYTE = 8'hc4;
  localparam logic [7:0] OP_WR_DBG_WORD = 8'hcc;
  localparam logic [7:0] OP_WR_BYTE = 8'hc0;
  localparam logic [7:0] OP_WR_WORD = 8'hc8;

  // debug window and register addresses
  localparam logic [15:0] DBG_WIN_BASE = 16'hff00;
  localparam logic [15:0] STATUS_ADDR = 16'hff01;
  localparam logic [15:0] CCR_HOLD_ADDR = 16'hff06;
  localparam logic [15:0] REG_POS_ADDR = 16'hff07;
  localparam int WIN_REG_LSB = 3;

  // reset and field layout
  localparam logic [7:0] CCR_HOLD_RST = 8'hd8;
  localparam int ST_ENABLE_BIT = 7;
  localparam int ST_ACTIVE_BIT = 6;
  localparam int ST_UNSECURE_BIT_BIT = 1;
  localparam int POS_FIELD_LSB = 3;
  localparam int POS_WIDTH = 4;

  // timing counts (bus clocks; WAIT_ONE and WAIT_TWO count instructions)
  localparam int STEAL_WAIT_CYC = 128;
  localparam logic [7:0] STEAL_LAST = 8'(STEAL_WAIT_CYC - 1);
  localparam logic [3:0] RESUME_DLY = 4'h8;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;

  typedef enum logic [2:0] {
    CMD_IDLE, CMD_ADDR_HI, CMD_ADDR_LO, CMD_DATA_HI, CMD_DATA_LO, CMD_ACCESS
  } cmd_state_t;

  typedef enum logic [1:0] {STL_IDLE, STL_WAIT, STL_BUS} steal_state_t;

endpackage : dbg_pkg

// file: core/dbg_bus_steal.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// bus cycle steal: waits for a free cpu cycle, freezes cpu if none
// ----------------------------------------------------------------
module dbg_bus_steal (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic cpu_free_cycle,
  input wire logic mem_done,
  output logic req_q,
  output logic freeze_q
);

  dbg_pkg::steal_state_t state_q;
  logic [7:0] cnt_q;
  logic limit_hit;

  assign limit_hit = (cnt_q == dbg_pkg::STEAL_LAST);

  // wait counter runs only while looking for a free cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst || state_q != dbg_pkg::STL_WAIT) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // free cycle found: no freeze until the access outlasts one cycle; limit reached: steal one
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= dbg_pkg::STL_IDLE;
      req_q <= 1'b0;
      freeze_q <= 1'b0;
    end else begin
      case (state_q)
        dbg_pkg::STL_IDLE: begin
          if (start && cpu_free_cycle) begin
            state_q <= dbg_pkg::STL_BUS;
            req_q <= 1'b1;
          end else if (start) begin
            state_q <= dbg_pkg::STL_WAIT;
          end
        end
        dbg_pkg::STL_WAIT: begin
          if (cpu_free_cycle || limit_hit) begin
            state_q <= dbg_pkg::STL_BUS;
            req_q <= 1'b1;
            freeze_q <= !cpu_free_cycle;
          end
        end
        dbg_pkg::STL_BUS: begin
          if (mem_done) begin
            state_q <= dbg_pkg::STL_IDLE;
            req_q <= 1'b0;
            freeze_q <= 1'b0;
          end else begin
            freeze_q <= 1'b1; // multi-cycle access freezes cpu until mem_done
          end
        end
        default: begin
          state_q <= dbg_pkg::STL_IDLE;
          req_q <= 1'b0;
          freeze_q <= 1'b0;
        end
      endcase
    end
  end

endmodule : dbg_bus_steal

`default_nettype wire

// file: core/single_wire_debug_command_unit.sv
`timescale 1ns/1ns
`default_nettype none

module single_wire_debug_command_unit (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic special_sc_mode,
  input wire logic secured,
  input wire logic flash_erased,
  input wire logic eeprom_erased,
  input wire logic host_byte_valid,
  input wire logic [7:0] host_byte,
  input wire logic cpu_instr_done,
  input wire logic cpu_halt_to_debug_instruction_instr,
  input wire logic tag_event,
  input wire logic brk_event,
  input wire logic brk_after_next,
  input wire logic cpu_exit_debug,
  input wire logic [7:0] cpu_ccr,
  input wire logic [3:0] init_reg_pos,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_free_cycle,
  input wire logic mem_done,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] host_rd_word_q,
  output logic host_rd_valid_q,
  output logic ack_pulse_q,
  output logic fw_cmd_valid_q,
  output logic [7:0] fw_cmd_q,
  output logic dbg_enabled_q,
  output logic dbg_active_q,
  output logic unsecure_bit_q,
  output logic cpu_halt_req_q,
  output logic cpu_hold_q,
  output logic [7:0] ccr_holding_q,
  output logic [7:0] cpu_rdata_q,
  output logic cpu_hit_q,
  output logic mem_req_q,
  output logic cpu_freeze_q,
  output logic [15:0] mem_addr_q,
  output logic mem_wr_q,
  output logic mem_byte_q,
  output logic [15:0] mem_wdata_q,
  output logic mem_dbgmap_q
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // register read mux for the debug window, shared by host and cpu paths
  function automatic logic [7:0] reg_rd(input logic [15:0] a, input logic [7:0] st,
                                        input logic [7:0] condition_code_register, input logic [7:0] pos);
    logic [7:0] r;
    r = 8'h00;
    if (a == dbg_pkg::STATUS_ADDR) begin
      r = st;
    end else if (a == dbg_pkg::CCR_HOLD_ADDR) begin
      r = condition_code_register;
    end else if (a == dbg_pkg::REG_POS_ADDR) begin
      r = pos;
    end
    return r;
  endfunction : reg_rd

  // true when the address lies in the eight-byte register window
  function automatic logic in_window(input logic [15:0] a);
    return a[15:dbg_pkg::WIN_REG_LSB] == dbg_pkg::DBG_WIN_BASE[15:dbg_pkg::WIN_REG_LSB];
  endfunction : in_window

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dbg_pkg::cmd_state_t state_q;
  logic wr_q, word_q, bd_q, start_q, ack_en_q, boot_q, secured_q;
  logic pend_q, pend_hw_q;
  logic [1:0] wait_q;
  logic [3:0] hold_cnt_q;
  logic [15:0] addr_q, data_q;
  logic [7:0] st_byte, pos_byte;
  logic steal_req;

  // opcode classes
  logic op_rd, op_wr, op_mem, op_enter, op_ack_on, op_ack_off, op_hw;
  logic op_word, op_bd;
  assign op_rd = (host_byte == dbg_pkg::OP_RD_DBG_BYTE) || (host_byte == dbg_pkg::OP_RD_DBG_WORD)
              || (host_byte == dbg_pkg::OP_RD_BYTE) || (host_byte == dbg_pkg::OP_RD_WORD);
  assign op_wr = (host_byte == dbg_pkg::OP_WR_DBG_BYTE) || (host_byte == dbg_pkg::OP_WR_DBG_WORD)
              || (host_byte == dbg_pkg::OP_WR_BYTE) || (host_byte == dbg_pkg::OP_WR_WORD);
  assign op_word = (host_byte == dbg_pkg::OP_RD_DBG_WORD) || (host_byte == dbg_pkg::OP_RD_WORD)
                || (host_byte == dbg_pkg::OP_WR_DBG_WORD) || (host_byte == dbg_pkg::OP_WR_WORD);
  assign op_bd = (host_byte == dbg_pkg::OP_RD_DBG_BYTE) || (host_byte == dbg_pkg::OP_RD_DBG_WORD)
              || (host_byte == dbg_pkg::OP_WR_DBG_BYTE) || (host_byte == dbg_pkg::OP_WR_DBG_WORD);
  assign op_mem = op_rd || op_wr;
  assign op_enter = (host_byte == dbg_pkg::OP_ENTER_DEBUG);
  assign op_ack_on = (host_byte == dbg_pkg::OP_ACK_ON);
  assign op_ack_off = (host_byte == dbg_pkg::OP_ACK_OFF);
  assign op_hw = op_mem || op_enter || op_ack_on || op_ack_off;

  // host command strobes, only taken while the parser is idle
  logic idle_byte, hw_enter, fw_ok;
  assign idle_byte = host_byte_valid && (state_q == dbg_pkg::CMD_IDLE);
  assign hw_enter = idle_byte && op_enter;
  assign fw_ok = dbg_active_q && (unsecure_bit_q || !secured_q);

  // access completion and register window hits
  logic int_hit, int_fin, ext_fin, fin, go_access;
  logic st_wr, ccr_wr_host, ccr_wr_cpu;
  logic [15:0] reg_word, rd_raw, rd_word;
  assign int_hit = bd_q && in_window(addr_q);
  assign int_fin = (state_q == dbg_pkg::CMD_ACCESS) && start_q && int_hit;
  assign ext_fin = steal_req && mem_done;
  assign fin = int_fin || ext_fin;
  assign go_access = host_byte_valid && (((state_q == dbg_pkg::CMD_ADDR_LO) && !wr_q)
                  || (state_q == dbg_pkg::CMD_DATA_LO));
  assign st_wr = int_fin && wr_q && (addr_q[15:1] == dbg_pkg::STATUS_ADDR[15:1])
              && (word_q || addr_q[0]);
  assign ccr_wr_host = int_fin && wr_q && (addr_q[15:1] == dbg_pkg::CCR_HOLD_ADDR[15:1])
                    && (word_q || !addr_q[0]);
  assign ccr_wr_cpu = cpu_wr && dbg_active_q && (cpu_addr == dbg_pkg::CCR_HOLD_ADDR);
  assign reg_word = {reg_rd({addr_q[15:1], 1'b0}, st_byte, ccr_holding_q, pos_byte),
                     reg_rd({addr_q[15:1], 1'b1}, st_byte, ccr_holding_q, pos_byte)};
  assign rd_raw = int_hit ? reg_word : mem_rdata;
  // byte reads keep only the addressed lane: odd low, even high
  assign rd_word = word_q ? rd_raw : (addr_q[0] ? {8'h00, rd_raw[7:0]} : {rd_raw[15:8], 8'h00});

  // status and position register images
  always_comb begin
    st_byte = 8'h00;
    st_byte[dbg_pkg::ST_ENABLE_BIT] = dbg_enabled_q;
    st_byte[dbg_pkg::ST_ACTIVE_BIT] = dbg_active_q;
    st_byte[dbg_pkg::ST_UNSECURE_BIT_BIT] = unsecure_bit_q;
    pos_byte = 8'h00;
    pos_byte[dbg_pkg::POS_FIELD_LSB +: dbg_pkg::POS_WIDTH] = init_reg_pos;
  end

  // activation sources and entry completion
  logic cpu_src, entry_done;
  assign cpu_src = cpu_halt_to_debug_instruction_instr || tag_event || brk_event;
  assign entry_done = pend_q && cpu_instr_done && (wait_q == dbg_pkg::WAIT_ONE);

  // ----------------------------------------------------------------
  // command parser: opcode, address, data, access
  // ----------------------------------------------------------------
  // bytes arriving during an access are dropped; the host pacing covers this
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= dbg_pkg::CMD_IDLE;
      wr_q <= 1'b0;
      word_q <= 1'b0;
      bd_q <= 1'b0;
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
    end else begin
      case (state_q)
        dbg_pkg::CMD_IDLE: begin
          if (host_byte_valid && op_mem) begin
            state_q <= dbg_pkg::CMD_ADDR_HI;
            wr_q <= op_wr;
            word_q <= op_word;
            bd_q <= op_bd;
          end
        end
        dbg_pkg::CMD_ADDR_HI: begin
          if (host_byte_valid) begin
            addr_q[15:8] <= host_byte;
            state_q <= dbg_pkg::CMD_ADDR_LO;
          end
        end
        dbg_pkg::CMD_ADDR_LO: begin
          if (host_byte_valid) begin
            // word accesses ignore the address lsb
            addr_q[7:0] <= {host_byte[7:1], host_byte[0] && !word_q};
            state_q <= wr_q ? dbg_pkg::CMD_DATA_HI : dbg_pkg::CMD_ACCESS;
          end
        end
        dbg_pkg::CMD_DATA_HI: begin
          if (host_byte_valid) begin
            data_q[15:8] <= host_byte;
            state_q <= dbg_pkg::CMD_DATA_LO;
          end
        end
        dbg_pkg::CMD_DATA_LO: begin
          if (host_byte_valid) begin
            data_q[7:0] <= host_byte;
            state_q <= dbg_pkg::CMD_ACCESS;
          end
        end
        dbg_pkg::CMD_ACCESS: begin
          if (fin) begin
            state_q <= dbg_pkg::CMD_IDLE;
          end
        end
        default: begin
          state_q <= dbg_pkg::CMD_IDLE;
        end
      endcase
    end
  end

  // access launch and bus-side command outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      start_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_wr_q <= 1'b0;
      mem_byte_q <= 1'b0;
      mem_wdata_q <= 16'h0000;
      mem_dbgmap_q <= 1'b0;
    end else begin
      start_q <= go_access;
      if (start_q) begin
        mem_addr_q <= addr_q;
        mem_wr_q <= wr_q;
        mem_byte_q <= !word_q;
        mem_wdata_q <= data_q;
      end
      // debug resources visible to the bus only for this one access
      mem_dbgmap_q <= bd_q && (state_q == dbg_pkg::CMD_ACCESS) && !int_hit && !ext_fin;
    end
  end

  // cycle stealing for accesses that miss the register window or are not bd accesses
  dbg_bus_steal u_steal (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(start_q && !int_hit),
    .cpu_free_cycle(cpu_free_cycle),
    .mem_done(mem_done),
    .req_q(mem_req_q),
    .freeze_q(cpu_freeze_q)
  );
  assign steal_req = mem_req_q;

  // ----------------------------------------------------------------
  // host answers: read data, acknowledge, firmware forwarding
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack_en_q <= 1'b0;
      ack_pulse_q <= 1'b0;
      host_rd_valid_q <= 1'b0;
      host_rd_word_q <= 16'h0000;
      fw_cmd_valid_q <= 1'b0;
      fw_cmd_q <= 8'h00;
    end else begin
      if (idle_byte && op_ack_on) begin
        ack_en_q <= 1'b1;
      end else if (idle_byte && op_ack_off) begin
        ack_en_q <= 1'b0;
      end
      // read data ready or write done, entry via 90, or d5 itself
      ack_pulse_q <= (ack_en_q && (fin || (entry_done && pend_hw_q))) || (idle_byte && op_ack_on);
      host_rd_valid_q <= fin && !wr_q;
      if (fin && !wr_q) begin
        host_rd_word_q <= rd_word;
      end
      fw_cmd_valid_q <= idle_byte && !op_hw && fw_ok;
      if (idle_byte && !op_hw) begin
        fw_cmd_q <= host_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable, active, security
  // ----------------------------------------------------------------
  // boot_q marks the first cycle after reset release; straps are caught here
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      boot_q <= 1'b1;
      secured_q <= 1'b0;
      dbg_enabled_q <= 1'b0;
      unsecure_bit_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        secured_q <= secured;
      end
      if (boot_q && special_sc_mode) begin
        dbg_enabled_q <= 1'b1;
        unsecure_bit_q <= secured && flash_erased && eeprom_erased;
      end else if (st_wr) begin
        dbg_enabled_q <= data_q[dbg_pkg::ST_ENABLE_BIT];
      end
    end
  end

  // activation: wait for the current instruction, or one more for a breakpoint with brk_after_next
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dbg_active_q <= 1'b0;
      pend_q <= 1'b0;
      pend_hw_q <= 1'b0;
      wait_q <= dbg_pkg::WAIT_ONE;
      cpu_halt_req_q <= 1'b0;
    end else begin
      cpu_halt_req_q <= entry_done;
      if (boot_q && special_sc_mode) begin
        dbg_active_q <= 1'b1;
      end else if (entry_done) begin
        dbg_active_q <= 1'b1;
        pend_q <= 1'b0;
      end else if (dbg_active_q && cpu_exit_debug) begin
        dbg_active_q <= 1'b0;
      end
      if (!pend_q && !dbg_active_q && dbg_enabled_q && (hw_enter || cpu_src)) begin
        pend_q <= 1'b1;
        pend_hw_q <= hw_enter && !cpu_src;
        wait_q <= (brk_event && brk_after_next) ? dbg_pkg::WAIT_TWO : dbg_pkg::WAIT_ONE;
      end else if (pend_q && cpu_instr_done && !entry_done) begin
        wait_q <= wait_q - dbg_pkg::WAIT_ONE;
      end
    end
  end

  // disabled entry attempt from the cpu stalls it briefly; the host command
  // path never reaches here, so an ignored 90 costs the cpu nothing
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_cnt_q <= 4'h0;
      cpu_hold_q <= 1'b0;
    end else if (!dbg_enabled_q && cpu_src) begin
      hold_cnt_q <= dbg_pkg::RESUME_DLY;
      cpu_hold_q <= 1'b1;
    end else if (hold_cnt_q != 4'h0) begin
      hold_cnt_q <= hold_cnt_q - 4'h1;
      cpu_hold_q <= (hold_cnt_q != 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // condition-code holding and cpu window access
  // ----------------------------------------------------------------
  // entry copy beats a host write, which beats a firmware write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ccr_holding_q <= dbg_pkg::CCR_HOLD_RST;
    end else if (entry_done) begin
      ccr_holding_q <= cpu_ccr;
    end else if (ccr_wr_host) begin
      ccr_holding_q <= data_q[15:8];
    end else if (ccr_wr_cpu) begin
      ccr_holding_q <= cpu_wdata;
    end
  end

  // user programs see nothing: the window only answers while active
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cpu_hit_q <= 1'b0;
      cpu_rdata_q <= 8'h00;
    end else begin
      cpu_hit_q <= cpu_rd && dbg_active_q && in_window(cpu_addr);
      cpu_rdata_q <= (cpu_rd && dbg_active_q)
                   ? reg_rd(cpu_addr, st_byte, ccr_holding_q, pos_byte) : 8'h00;
    end
  end

endmodule : single_wire_debug_command_unit

`default_nettype wire

// file: verif/dbg_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------
// bus memory partner
// --------------------
module dbg_mem_model #(parameter int LAT = 2) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic map,
  output logic done,
  output logic [15:0] rdata,
  output logic [15:0] seen_addr,
  output logic [15:0] seen_wdata,
  output logic seen_map
);
  logic [3:0] cnt_q;
  // fixed latency, so every access costs the unit a multi-cycle wait
  always_ff @(posedge ref_clk) begin
    cnt_q <= (!nrst || !req || done) ? 4'h0 : cnt_q + 4'h1;
  end
  assign done = req && (cnt_q == 4'(LAT));
  // done-cycle data is the inverted address so a stale sample never matches
  assign rdata = done ? ~addr : addr;
  // remember the last completed access for the bench
  always_ff @(posedge ref_clk) begin
    if (done) begin
      seen_addr <= addr;
      seen_wdata <= wdata;
      seen_map <= map;
    end
  end
endmodule : dbg_mem_model
`default_nettype wire

// file: verif/dbg_cmd_checker.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------
// port checks
// --------------------
module dbg_cmd_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic special_sc_mode,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_ccr,
  input wire logic mem_done,
  input wire logic mem_req_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic fw_cmd_valid_q,
  input wire logic dbg_enabled_q,
  input wire logic dbg_active_q,
  input wire logic unsecure_bit_q,
  input wire logic cpu_halt_req_q,
  input wire logic [7:0] ccr_holding_q,
  input wire logic cpu_hit_q
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_ccr_reset_value: assert property (!$past(nrst) |-> ccr_holding_q == 8'hd8)
    else $error("ccr holding not d8 after reset");
  a_entry_ccr_copy: assert property (
    $rose(dbg_active_q) && !special_sc_mode |-> ccr_holding_q == $past(cpu_ccr))
    else $error("ccr not copied on entry");
  a_req_until_done: assert property (mem_req_q && !mem_done |=> mem_req_q)
    else $error("access dropped before done");
  a_req_drop_done: assert property (mem_req_q && mem_done |=> !mem_req_q)
    else $error("access held after done");
  a_addr_steady: assert property (mem_req_q && $past(mem_req_q) |-> $stable(mem_addr_q))
    else $error("address moved during access");
  a_fw_only_active: assert property (fw_cmd_valid_q |-> $past(dbg_active_q))
    else $error("firmware byte while inactive");
  a_hit_only_active: assert property (cpu_hit_q |-> $past(cpu_rd) && $past(dbg_active_q))
    else $error("window hit while inactive");
  a_unsecure_bit_needs_en: assert property (unsecure_bit_q |-> dbg_enabled_q)
    else $error("unsecure without enable");
  a_active_needs_en: assert property (dbg_active_q |-> dbg_enabled_q)
    else $error("active without enable");
  a_halt_needs_en: assert property (cpu_halt_req_q |-> dbg_enabled_q)
    else $error("halt while disabled");
  c_steal: cover property (mem_req_q && mem_done);
  c_entry: cover property ($rose(dbg_active_q));
  c_fw: cover property (fw_cmd_valid_q);
endmodule : dbg_cmd_checker
bind single_wire_debug_command_unit dbg_cmd_checker dbg_cmd_checker_inst (
  .ref_clk(ref_clk), .nrst(nrst), .special_sc_mode(special_sc_mode), .cpu_rd(cpu_rd),
  .cpu_ccr(cpu_ccr), .mem_done(mem_done), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
  .fw_cmd_valid_q(fw_cmd_valid_q), .dbg_enabled_q(dbg_enabled_q), .dbg_active_q(dbg_active_q),
  .unsecure_bit_q(unsecure_bit_q), .cpu_halt_req_q(cpu_halt_req_q), .ccr_holding_q(ccr_holding_q),
  .cpu_hit_q(cpu_hit_q));
`default_nettype wire

// file: verif/single_wire_debug_command_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none
module single_wire_debug_command_unit_bench;
  logic ref_clk = 1'b0, nrst = 1'b0, special_sc_mode = 1'b0, secured = 1'b0;
  logic flash_erased = 1'b0, eeprom_erased = 1'b0, host_byte_valid = 1'b0;
  logic cpu_instr_done = 1'b0, cpu_halt_to_debug_instruction_instr = 1'b0, cpu_exit_debug = 1'b0;
  logic cpu_rd = 1'b0, cpu_free_cycle = 1'b1, mem_done, seen_map, mem_req_q, mem_dbgmap_q;
  logic [7:0] host_byte = 8'h00, cpu_ccr = 8'h00, ccr_holding_q, cpu_rdata_q, fw_cmd_q;
  logic [3:0] init_reg_pos = 4'h0;
  logic [15:0] cpu_addr = 16'h0000, mem_rdata, mem_addr_q, mem_wdata_q, seen_addr, seen_wdata;
  logic [15:0] host_rd_word_q, rd_w, cpu_w;
  logic mem_wr_q, mem_byte_q;
  logic host_rd_valid_q, ack_pulse_q, fw_cmd_valid_q, dbg_enabled_q, dbg_active_q, unsecure_bit_q;
  logic cpu_hold_q, cpu_hit_q, cpu_freeze_q, got_ack, got_frz, got_fw, got_hold;
  int err_total = 0, checks_done = 0, cyc = 0;
  single_wire_debug_command_unit single_wire_debug_command_unit_inst (
    .ref_clk(ref_clk), .nrst(nrst), .special_sc_mode(special_sc_mode), .secured(secured),
    .flash_erased(flash_erased), .eeprom_erased(eeprom_erased),
    .host_byte_valid(host_byte_valid), .host_byte(host_byte), .cpu_instr_done(cpu_instr_done),
    .cpu_halt_to_debug_instruction_instr(cpu_halt_to_debug_instruction_instr), .tag_event(1'b0), .brk_event(1'b0), .brk_after_next(1'b0),
    .cpu_exit_debug(cpu_exit_debug), .cpu_ccr(cpu_ccr), .init_reg_pos(init_reg_pos),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(1'b0), .cpu_wdata(8'h00),
    .cpu_free_cycle(cpu_free_cycle), .mem_done(mem_done), .mem_rdata(mem_rdata),
    .host_rd_word_q(host_rd_word_q), .host_rd_valid_q(host_rd_valid_q),
    .ack_pulse_q(ack_pulse_q), .fw_cmd_valid_q(fw_cmd_valid_q), .fw_cmd_q(fw_cmd_q),
    .dbg_enabled_q(dbg_enabled_q), .dbg_active_q(dbg_active_q), .unsecure_bit_q(unsecure_bit_q),
    .cpu_halt_req_q(), .cpu_hold_q(cpu_hold_q), .ccr_holding_q(ccr_holding_q),
    .cpu_rdata_q(cpu_rdata_q), .cpu_hit_q(cpu_hit_q), .mem_req_q(mem_req_q),
    .cpu_freeze_q(cpu_freeze_q), .mem_addr_q(mem_addr_q), .mem_wr_q(mem_wr_q),
    .mem_byte_q(mem_byte_q),
    .mem_wdata_q(mem_wdata_q), .mem_dbgmap_q(mem_dbgmap_q));
  dbg_mem_model dbg_mem_model_inst (
    .ref_clk(ref_clk), .nrst(nrst), .req(mem_req_q), .addr(mem_addr_q), .wdata(mem_wdata_q),
    .map(mem_dbgmap_q), .done(mem_done), .rdata(mem_rdata), .seen_addr(seen_addr),
    .seen_wdata(seen_wdata), .seen_map(seen_map));
  // clock, instruction pacing and hang guard (run needs about 4000 cycles)
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cpu_instr_done <= ~cpu_instr_done;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      conclude();
    end
  end
  // --------------------
  // tasks
  // --------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rst(input logic s, input logic c, input logic f, input logic e);
    @(posedge ref_clk);
    {special_sc_mode, secured, flash_erased, eeprom_erased} <= {s, c, f, e};
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask : rst
  task automatic tx(input logic [7:0] b);
    @(posedge ref_clk);
    host_byte <= b;
    host_byte_valid <= 1'b1;
    @(posedge ref_clk);
    host_byte_valid <= 1'b0;
  endtask : tx
  // opcode then msb-first bytes, then a window longer than the host's wait
  task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input int n);
    {got_ack, got_frz, got_fw} = 3'b000;
    rd_w = 16'hxxxx;
    tx(op);
    for (int i = 0; i < n; i++) begin
      tx(ad[31-8*i -: 8]);
    end
    repeat (200) begin
      @(negedge ref_clk);
      {got_ack, got_frz, got_fw} |= {ack_pulse_q, cpu_freeze_q, fw_cmd_valid_q};
      rd_w = host_rd_valid_q ? host_rd_word_q : rd_w;
    end
  endtask : cmd
  task automatic pulse_cpu(input logic [15:0] a, input logic bg);
    @(posedge ref_clk);
    {cpu_addr, cpu_rd, cpu_halt_to_debug_instruction_instr} <= {a, ~bg, bg};
    @(posedge ref_clk);
    {cpu_rd, cpu_halt_to_debug_instruction_instr} <= 2'b00;
    // the window answer stands for one cycle only, so take it at the first negedge
    @(negedge ref_clk);
    cpu_w = {cpu_rdata_q, 7'h0, cpu_hit_q};
    got_hold = cpu_hold_q;
    repeat (4) @(negedge ref_clk) got_hold |= cpu_hold_q;
  endtask : pulse_cpu
  // --------------------
  // scenarios
  // --------------------
  task automatic t_boot();
    @(posedge ref_clk) init_reg_pos <= 4'ha;
    rst(1'b1, 1'b0, 1'b0, 1'b0);
    chk(16'({dbg_enabled_q, dbg_active_q}), 16'h0003);
    chk(16'(ccr_holding_q), 16'h00d8);
    cmd(8'hd5, 32'h0, 0);
    chk(16'(got_ack), 16'h0001);
    cmd(8'he4, 32'hff06_0000, 2);
    chk(rd_w, 16'hd800);
    chk(16'(got_ack), 16'h0001);
    cmd(8'hc4, 32'hff06_a500, 4);
    chk(16'(ccr_holding_q), 16'h00a5);
    cmd(8'hc4, 32'hff07_0011, 4);
    cmd(8'hec, 32'hff07_0000, 2);
    chk(rd_w, 16'ha550);
    pulse_cpu(16'hff06, 1'b0);
    chk(cpu_w, 16'ha501);
  endtask : t_boot
  task automatic t_mem();
    @(posedge ref_clk);
    cpu_free_cycle <= 1'b0;
    cmd(8'he8, 32'h1235_0000, 2);
    chk(rd_w, 16'hedcb);
    chk(16'(got_frz), 16'h0001);
    @(posedge ref_clk) cpu_free_cycle <= 1'b1;
    cmd(8'hc8, 32'h2001_beef, 4);
    chk(seen_addr, 16'h2000);
    chk({seen_wdata[15:1], seen_map}, 16'hbeee);
    cmd(8'hcc, 32'h3000_1234, 4);
    chk(16'(seen_map), 16'h0001);
    cmd(8'hc0, 32'h5003_0077, 4);
    chk(seen_addr, 16'h5003);
    chk(16'({mem_wr_q, mem_byte_q}), 16'h0003);
    cmd(8'hd6, 32'h0, 0);
    cmd(8'he0, 32'h4001_0000, 2);
    chk({got_ack, 7'h0, rd_w[7:0]}, 16'h00fe);
  endtask : t_mem
  task automatic t_dis();
    rst(1'b0, 1'b0, 1'b0, 1'b0);
    chk(16'(dbg_enabled_q), 16'h0000);
    cmd(8'h90, 32'h0, 0);
    chk(16'(dbg_active_q), 16'h0000);
    pulse_cpu(16'hff06, 1'b1);
    chk(16'({got_hold, dbg_active_q}), 16'h0002);
    pulse_cpu(16'hff06, 1'b0);
    chk(cpu_w, 16'h0000);
    cmd(8'hc4, 32'hff01_0080, 4);
    chk(16'(dbg_enabled_q), 16'h0001);
    cmd(8'hd5, 32'h0, 0);
    @(posedge ref_clk) cpu_ccr <= 8'h3c;
    cmd(8'h90, 32'h0, 0);
    chk({dbg_active_q, got_ack, 6'h0, ccr_holding_q}, 16'hc03c);
    @(posedge ref_clk);
    cpu_exit_debug <= 1'b1;
    @(posedge ref_clk);
    cpu_exit_debug <= 1'b0;
    cmd(8'h62, 32'h0, 0);
    chk(16'(got_fw), 16'h0000);
  endtask : t_dis
  task automatic t_sec();
    rst(1'b1, 1'b1, 1'b1, 1'b1);
    chk(16'(unsecure_bit_q), 16'h0001);
    cmd(8'h62, 32'h0, 0);
    chk(16'(got_fw), 16'h0001);
    chk(16'(fw_cmd_q), 16'h0062);
    rst(1'b1, 1'b1, 1'b1, 1'b0);
    chk(16'({dbg_enabled_q, unsecure_bit_q}), 16'h0002);
    cmd(8'h62, 32'h0, 0);
    chk(16'(got_fw), 16'h0000);
    cmd(8'he4, 32'hff06_0000, 2);
    chk(rd_w, 16'hd800);
  endtask : t_sec
  initial begin
    t_boot();
    t_mem();
    t_dis();
    t_sec();
    conclude();
  end
endmodule : single_wire_debug_command_unit_bench
`default_nettype wire
